// ### logic/hpc_fault_timer.sv
// Purpose: overcurrent persistence timer for one supply channel
// Assumes: run_i is high only while the channel is on and overloaded
// Notes:   restarts from zero whenever the overload goes away
`timescale 1ns/1ps
module hpc_fault_timer
  import hpc_pkg::*;
(
  input  wire logic             clock_i,
  input  wire logic             reset_n_i,
  input  wire logic             ce_i,
  input  wire logic             run_i,
  input  wire logic [CNT_W-1:0] limit_i,
  output logic                  expired_o
);
  logic [CNT_W-1:0] count;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      count     <= '0;
      expired_o <= 1'b0;
    end else if (ce_i) begin
      if (!run_i) begin
        count     <= '0;
        expired_o <= 1'b0;
      end else if (count >= limit_i - 1'b1) begin
        expired_o <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end
endmodule // hpc_fault_timer

// ### logic/hpc_pkg.sv
// Purpose: shared constants and carriers for the slot power controller
// Assumes: 50 MHz core clock, 32-bit AXI4-Lite register port
// Notes:   long counts are overridable from the top-level parameters
package hpc_pkg;

  // timing
  localparam int CLOCK_MHZ     = 50;
  localparam int INIT_TIME_US  = 250;
  localparam int INIT_CYCLES   = INIT_TIME_US * CLOCK_MHZ;
  localparam int FAULT_TIME_US = 10000;
  localparam int FAULT_CYCLES  = FAULT_TIME_US * CLOCK_MHZ;
  localparam int CNT_W         = 20;

  // register byte offsets
  localparam logic [31:0] OFS_CONTROL  = 32'h0000_0000;
  localparam logic [31:0] OFS_FUNCTION = 32'h0000_0004;
  localparam logic [31:0] OFS_SLOT_ST  = 32'h0000_0008;
  localparam logic [31:0] OFS_COMMON   = 32'h0000_000c;

  // control register fields
  localparam int CTRL_AUX_ON  = 0;
  localparam int CTRL_MAIN_ON = 1;
  // function register fields
  localparam int FUNC_AUX_HIGH = 0;
  // slot status fields
  localparam int SLOT_FAULT    = 0;
  localparam int SLOT_AUX_F    = 1;
  localparam int SLOT_12V_F    = 2;
  localparam int SLOT_3V_F     = 3;
  localparam int SLOT_POWER_GOOD_INDICATION    = 4;
  localparam int SLOT_PWR_OFF  = 5;
  localparam int SLOT_REG_MODE = 6;
  localparam int SLOT_AUX_EN   = 7;
  localparam int SLOT_MAIN_EN  = 8;
  localparam int SLOT_AUX_HIGH = 9;
  localparam int SLOT_INIT_OK  = 10;
  // common status fields
  localparam int COM_AUX_F = 0;
  localparam int COM_12V_F = 1;
  localparam int COM_3V_F  = 2;
  localparam int COM_UV    = 3;

  // reset values
  localparam logic       RST_REG_MODE  = 1'b0;
  localparam logic [1:0] RST_CONTROL   = 2'h0;
  localparam logic       RST_AUX_HIGH  = 1'b0;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic main_on_pin;
    logic aux_enable_pin;
    logic force_power_on_n;
    logic aux_high_current_select;
  } hpc_pins_t;

  typedef struct packed {
    logic main12_uv;
    logic main33_uv;
    logic main12_oc;
    logic main33_oc;
    logic aux_oc;
    logic fast_oc;
    logic thermal_limit_low;
    logic thermal_limit_high;
    logic slot_output_good;
    logic slot_bled_low;
  } hpc_sense_t;

  typedef enum logic [0:0] {
    HPC_INIT,
    HPC_RUN
  } hpc_state_t;

endpackage

// ### logic/hpc_slot_ctrl.sv
// Purpose: power sequencing, fault handling and registers for one slot
// Assumes: analog comparators arrive as async levels in sense_i
// Notes:   reset_n_i stands for the logic-supply power-on reset
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - supply reset clears registers, outputs off
// - initialization ends within 250 microseconds
// - main off after reset, fault clear
// - aux enable pin is level sensitive
// - force-on drives aux and main on
// - direct pin mode or register mode
// - status readable over bus in direct mode
// - control write in direct mode selects register mode
// - aux limit low default, high selectable
// - function bit changes aux limit anytime
// - high-current pin overrides low request
// - aux off after overcurrent outlasts timer
// - power-good asserts above output undervoltage
// - power-off flag when bled below 100 mV
// - fault on main commanded with undervoltage
// - fault on overcurrent with timer or low thermal
// - immediate fault on fast trip or high thermal
// - direct mode: fault pin and status bit
// - register mode: flags only, pin quiet
// - power-good drops with slot undervoltage
// - faults held until matching enable drops
module hpc_slot_ctrl
  import hpc_pkg::*;
#(
  parameter logic [CNT_W-1:0] INIT_LEN  = CNT_W'(INIT_CYCLES),
  parameter logic [CNT_W-1:0] FAULT_LEN = CNT_W'(FAULT_CYCLES)
) (
  input  wire logic               clock_i,
  input  wire logic               reset_n_i,
  input  wire logic               ce_i,
  // slot pins and comparators, asynchronous
  input  wire hpc_pkg::hpc_pins_t  pins_i,
  input  wire hpc_pkg::hpc_sense_t sense_i,
  // AXI4-Lite slave
  input  wire logic [31:0]        awaddr_i,
  input  wire logic               awvalid_i,
  output logic                    awready_o,
  input  wire logic [31:0]        wdata_i,
  input  wire logic [3:0]         wstrb_i,
  input  wire logic               wvalid_i,
  output logic                    wready_o,
  output logic [1:0]              bresp_o,
  output logic                    bvalid_o,
  input  wire logic               bready_i,
  input  wire logic [31:0]        araddr_i,
  input  wire logic               arvalid_i,
  output logic                    arready_o,
  output logic [31:0]             rdata_o,
  output logic [1:0]              rresp_o,
  output logic                    rvalid_o,
  input  wire logic               rready_i,
  // slot drive
  output logic                    aux_slot_output_o,
  output logic                    main_slot_output_o,
  output logic                    aux_high_current_o,
  output logic                    slot_fault_out_n_o,
  output logic                    slot_fault_out_n_oe_o,
  output logic                    slot_power_good_n_o,
  output logic                    slot_power_good_n_oe_o,
  output logic                    init_done_o
);
  import hpc_pkg::*;
  hpc_pins_t        pins;
  hpc_sense_t       sense;
  hpc_state_t       state;
  logic [CNT_W-1:0] init_cnt;
  logic [1:0]       control;
  logic             init_done, reg_mode, func_aux_high, main_armed;
  logic             aux_fault_flag, fault_twelve_volt_flag;
  logic             fault_three_volt_flag, undervoltage_irq_flag;
  logic             slot_power_off_flag, aux_expired, main_expired;
  logic             aux_cmd, main_cmd, force_on, main_fault, any_fault;
  logic             set_aux, set_12, set_33, set_uv;
  logic             next_aux_on, next_main_on, aw_take, ar_take;
  logic [31:0]      slot_status, common_status, next_rdata;
  logic [1:0]       next_rresp;
  hpc_sync #(.W($bits(hpc_pins_t))) u_sync_pins (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .d_i       (pins_i),
    .q_o       (pins)
  );
  hpc_sync #(.W($bits(hpc_sense_t))) u_sync_sense (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .d_i       (sense_i),
    .q_o       (sense)
  );
  // aux channel is never subject to the fast trip
  hpc_fault_timer u_aux_timer (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .run_i     (aux_slot_output_o & sense.aux_oc),
    .limit_i   (FAULT_LEN),
    .expired_o (aux_expired)
  );
  hpc_fault_timer u_main_timer (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .run_i     (main_slot_output_o & (sense.main12_oc | sense.main33_oc)),
    .limit_i   (FAULT_LEN),
    .expired_o (main_expired)
  );
  // power-on initialization
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state    <= HPC_INIT;
      init_cnt <= '0;
    end else if (ce_i) begin
      case (state)
        HPC_INIT: begin
          if (init_cnt == INIT_LEN - 1'b1) begin
            state <= HPC_RUN;
          end else begin
            init_cnt <= init_cnt + 1'b1;
          end
        end
        HPC_RUN:  state <= HPC_RUN;
        default:  state <= HPC_INIT;
      endcase
    end
  end
  assign init_done   = (state == HPC_RUN);
  assign init_done_o = init_done;
  // a main-on pin already high at reset must be seen low before it counts
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      main_armed <= 1'b0;
    end else if (ce_i && init_done && !pins.main_on_pin) begin
      main_armed <= 1'b1;
    end
  end
  // command sources
  always_comb begin
    force_on = !pins.force_power_on_n;
    if (reg_mode) begin
      aux_cmd  = control[CTRL_AUX_ON];
      main_cmd = control[CTRL_MAIN_ON];
    end else begin
      aux_cmd  = pins.aux_enable_pin;
      main_cmd = pins.main_on_pin & main_armed;
    end
  end
  // fault causes
  always_comb begin
    set_uv  = main_cmd & (sense.main12_uv | sense.main33_uv);
    set_aux = (sense.aux_oc & (aux_expired | sense.thermal_limit_low))
              | sense.thermal_limit_high;
    set_12  = (main_cmd & sense.main12_uv)
              | (sense.main12_oc & (main_expired | sense.thermal_limit_low))
              | sense.fast_oc | sense.thermal_limit_high;
    set_33  = (main_cmd & sense.main33_uv)
              | (sense.main33_oc & (main_expired | sense.thermal_limit_low))
              | sense.fast_oc | sense.thermal_limit_high;
  end
  // sticky flags: a new cause wins over the clear from a dropped enable
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      aux_fault_flag         <= 1'b0;
      fault_twelve_volt_flag <= 1'b0;
      fault_three_volt_flag  <= 1'b0;
      undervoltage_irq_flag  <= 1'b0;
    end else if (ce_i && init_done) begin
      aux_fault_flag         <= set_aux | (aux_fault_flag & aux_cmd);
      fault_twelve_volt_flag <= set_12
                                | (fault_twelve_volt_flag & main_cmd);
      fault_three_volt_flag  <= set_33
                                | (fault_three_volt_flag & main_cmd);
      undervoltage_irq_flag  <= set_uv
                                | (undervoltage_irq_flag & main_cmd);
    end
  end
  assign main_fault = fault_twelve_volt_flag | fault_three_volt_flag
                      | undervoltage_irq_flag;
  assign any_fault  = aux_fault_flag | main_fault;
  // switch decisions; force-on overrides faults but not the high thermal
  always_comb begin
    next_aux_on  = init_done & !sense.thermal_limit_high
                   & (force_on | (aux_cmd & !aux_fault_flag & !set_aux));
    next_main_on = init_done & !sense.thermal_limit_high
                   & (force_on | (main_cmd & !main_fault
                                  & !set_12 & !set_33 & !set_uv));
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      aux_slot_output_o  <= 1'b0;
      main_slot_output_o <= 1'b0;
      aux_high_current_o <= 1'b0;
    end else if (ce_i) begin
      aux_slot_output_o  <= next_aux_on;
      main_slot_output_o <= next_main_on;
      aux_high_current_o <= pins.aux_high_current_select
                            | func_aux_high;
    end
  end
  // open-drain indications, driven low when active
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      slot_fault_out_n_oe_o  <= 1'b0;
      slot_power_good_n_oe_o <= 1'b0;
      slot_power_off_flag    <= 1'b0;
    end else if (ce_i) begin
      slot_fault_out_n_oe_o  <= init_done & !reg_mode & any_fault;
      slot_power_good_n_oe_o <= main_slot_output_o
                                & sense.slot_output_good;
      slot_power_off_flag    <= init_done & !main_slot_output_o
                                & sense.slot_bled_low;
    end
  end
  assign slot_fault_out_n_o  = 1'b0;
  assign slot_power_good_n_o = 1'b0;
  // register writes
  assign aw_take   = ce_i & awvalid_i & wvalid_i & !bvalid_o;
  assign awready_o = aw_take;
  assign wready_o  = aw_take;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      reg_mode      <= RST_REG_MODE;
      control       <= RST_CONTROL;
      func_aux_high <= RST_AUX_HIGH;
    end else if (aw_take) begin
      if (awaddr_i == OFS_CONTROL) begin
        reg_mode <= 1'b1;
        if (wstrb_i[0]) begin
          control <= wdata_i[CTRL_MAIN_ON:CTRL_AUX_ON];
        end
      end
      if (awaddr_i == OFS_FUNCTION && wstrb_i[0]) begin
        func_aux_high <= wdata_i[FUNC_AUX_HIGH];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      bvalid_o <= 1'b0;
      bresp_o  <= RESP_OKAY;
    end else if (ce_i) begin
      if (aw_take) begin
        bvalid_o <= 1'b1;
        bresp_o  <= (awaddr_i == OFS_CONTROL || awaddr_i == OFS_FUNCTION)
                    ? RESP_OKAY : RESP_SLVERR;
      end else if (bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end
  // status words; fault bit only reflects direct mode
  always_comb begin
    slot_status                = '0;
    slot_status[SLOT_FAULT]    = !reg_mode & any_fault;
    slot_status[SLOT_AUX_F]    = aux_fault_flag;
    slot_status[SLOT_12V_F]    = fault_twelve_volt_flag;
    slot_status[SLOT_3V_F]     = fault_three_volt_flag;
    slot_status[SLOT_POWER_GOOD_INDICATION]    = slot_power_good_n_oe_o;
    slot_status[SLOT_PWR_OFF]  = slot_power_off_flag;
    slot_status[SLOT_REG_MODE] = reg_mode;
    slot_status[SLOT_AUX_EN]   = aux_slot_output_o;
    slot_status[SLOT_MAIN_EN]  = main_slot_output_o;
    slot_status[SLOT_AUX_HIGH] = aux_high_current_o;
    slot_status[SLOT_INIT_OK]  = init_done;
    common_status              = '0;
    common_status[COM_AUX_F]   = aux_fault_flag;
    common_status[COM_12V_F]   = fault_twelve_volt_flag;
    common_status[COM_3V_F]    = fault_three_volt_flag;
    common_status[COM_UV]      = undervoltage_irq_flag;
  end
  // register reads stay open in both modes
  always_comb begin
    next_rresp = RESP_OKAY;
    case (araddr_i)
      OFS_CONTROL:  next_rdata = {30'h0, control};
      OFS_FUNCTION: next_rdata = {31'h0, func_aux_high};
      OFS_SLOT_ST:  next_rdata = slot_status;
      OFS_COMMON:   next_rdata = common_status;
      default: begin
        next_rdata = 32'h0;
        next_rresp = RESP_SLVERR;
      end
    endcase
  end

  assign ar_take   = ce_i & arvalid_i & !rvalid_o;
  assign arready_o = ce_i & !rvalid_o;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rvalid_o <= 1'b0;
      rdata_o  <= 32'h0;
      rresp_o  <= RESP_OKAY;
    end else if (ce_i) begin
      if (ar_take) begin
        rvalid_o <= 1'b1;
        rdata_o  <= next_rdata;
        rresp_o  <= next_rresp;
      end else if (rready_i) begin
        rvalid_o <= 1'b0;
      end
    end
  end
  // checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);
  sequence s_ctrl_write;
    aw_take && awaddr_i == OFS_CONTROL;
  endsequence
  sequence s_aux_trip;
    ce_i && init_done && aux_slot_output_o && sense.aux_oc && aux_expired
      && pins.force_power_on_n;
  endsequence
  chk_reset_all_off: assert property (
    $rose(reset_n_i) |-> !aux_slot_output_o && !main_slot_output_o
      && !reg_mode && !any_fault)
    else $error("outputs or flags not cleared by reset");
  chk_init_length: assert property (
    ce_i && state == HPC_INIT && init_cnt == INIT_LEN - 1'b1 |=> init_done)
    else $error("initialization did not finish on time");
  chk_init_quiet: assert property (
    !init_done |-> !main_slot_output_o && !slot_fault_out_n_oe_o)
    else $error("main power or fault active during initialization");
  chk_force_both_on: assert property (
    ce_i && init_done && !pins.force_power_on_n
      && !sense.thermal_limit_high
      |=> aux_slot_output_o && main_slot_output_o)
    else $error("force-on did not switch both supplies on");
  chk_ctrl_mode_switch: assert property (
    s_ctrl_write |=> reg_mode ##1 reg_mode)
    else $error("control write did not select register mode");
  chk_aux_high_pin: assert property (
    ce_i && pins.aux_high_current_select |=> aux_high_current_o)
    else $error("high-current pin overridden");
  chk_aux_oc_off: assert property (
    s_aux_trip |=> !aux_slot_output_o && aux_fault_flag)
    else $error("aux stayed on after fault timer expired");
  chk_power_off_flag: assert property (
    ce_i && init_done && !main_slot_output_o && sense.slot_bled_low
      |=> slot_power_off_flag)
    else $error("power-off flag missing after bleed-down");
  chk_direct_fault_pin: assert property (
    ce_i && init_done && !reg_mode && any_fault
      |=> slot_fault_out_n_oe_o || reg_mode)
    else $error("fault pin not driven in direct mode");
  chk_reg_pin_quiet: assert property (
    reg_mode && $past(reg_mode) |-> !slot_fault_out_n_oe_o)
    else $error("fault pin driven in register mode");
  chk_fault_held: assert property (
    ce_i && init_done && aux_fault_flag && aux_cmd |=> aux_fault_flag)
    else $error("aux fault cleared while enable still high");
endmodule // hpc_slot_ctrl

// ### logic/hpc_sync.sv
// Purpose: two-stage synchroniser for a bundle of asynchronous levels
// Assumes: each bit is an independent level, no multi-bit coherence
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
module hpc_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         reset_n_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else if (ce_i) begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule // hpc_sync

// ### sim/hpc_host_model.sv
// Purpose: host side that sequences the slot enable pins
// Assumes: insert_i high asks for a powered slot, low for removal
// Notes:   STEP sets how promptly or slowly the host reacts
`timescale 1ns/1ps
module hpc_host_model #(
  parameter int STEP = 3
) (
  input  wire logic clock_i,
  input  wire logic insert_i,
  output logic      main_on_pin_o,
  output logic      aux_enable_pin_o
);
  int wait_cnt = 0;

  // one counter orders both edges: aux leads on the way up, trails down
  always @(posedge clock_i) begin
    if (insert_i) begin
      if (wait_cnt < 2 * STEP) wait_cnt <= wait_cnt + 1;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end

  assign aux_enable_pin_o = wait_cnt > 0;
  // the quiet spell before aux drops stands for module reset
  assign main_on_pin_o    = wait_cnt > STEP;
endmodule // hpc_host_model

// ### sim/hpc_slot_ctrl_tb.sv
// Purpose: self-checking bench for the slot power controller
// Assumes: short init and fault counts set through parameters
// Notes:   enable pins come from the host model; force, high-current select, sense and bus from here
`timescale 1ns/1ps
module hpc_slot_ctrl_tb;
  import hpc_pkg::*;
  localparam int INIT_N = 20;
  localparam int FLT_N  = 16;
  logic        clock = 1'b0, reset_n = 1'b0, insert = 1'b1;
  logic        force_n = 1'b1, hi_sel = 1'b0;
  logic        main_on, aux_en;
  hpc_sense_t  sense = '0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, v;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic        aux_out, main_out, aux_hi, flt_oe, pg_oe, init_done;
  logic        flt_d, pg_d;
  int          n_fail = 0, comparisons = 0, cycles = 0;
  hpc_sense_t  cause [5] = '{10'h200, 10'h100, 10'h010, 10'h004, 10'h0c8};

  always #10 clock = ~clock;

  hpc_host_model #(.STEP(3)) host (.clock_i(clock), .insert_i(insert),
    .main_on_pin_o(main_on), .aux_enable_pin_o(aux_en));

  hpc_slot_ctrl #(.INIT_LEN(CNT_W'(INIT_N)), .FAULT_LEN(CNT_W'(FLT_N))) dut (
    .clock_i(clock), .reset_n_i(reset_n), .ce_i(1'b1),
    .pins_i({main_on, aux_en, force_n, hi_sel}), .sense_i(sense),
    .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready),
    .wdata_i(wdata), .wstrb_i(4'hf), .wvalid_i(wvalid), .wready_o(wready),
    .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(1'b1),
    .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready),
    .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(1'b1),
    .aux_slot_output_o(aux_out), .main_slot_output_o(main_out),
    .aux_high_current_o(aux_hi), .slot_fault_out_n_o(flt_d),
    .slot_fault_out_n_oe_o(flt_oe), .slot_power_good_n_o(pg_d),
    .slot_power_good_n_oe_o(pg_oe), .init_done_o(init_done));

  task automatic results();
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ceiling well above the roughly 420 cycles the sequence needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      results();
    end
  end

  task automatic chk(input logic s, input logic e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %0t seen %b expected %b", $time, s, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // response channels keep ready high, so only valids move here
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clock); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clock); while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic rd(input logic [31:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
  endtask

  task automatic wait_init();
    int n;
    n = 0;
    while (init_done !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    chk(n <= INIT_N + 4, 1'b1);
  endtask

  initial begin
    cyc(4);
    chk(aux_out | main_out | flt_oe, 1'b0);
    reset_n <= 1'b1;
    cyc(2);
    rd(OFS_SLOT_ST);
    chk(v[SLOT_INIT_OK] === 1'b0 && r === RESP_OKAY, 1'b1);
    wait_init();
    cyc(6);
    chk(aux_out, 1'b1);
    chk(main_out | flt_oe, 1'b0);
    chk(aux_hi, 1'b0);
    insert <= 1'b0;
    cyc(12);
    insert <= 1'b1;
    cyc(12);
    chk(main_out, 1'b1);
    sense.slot_output_good <= 1'b1;
    cyc(6);
    chk(pg_oe, 1'b1);
    chk(pg_d, 1'b0);
    sense.slot_output_good <= 1'b0;
    cyc(6);
    chk(pg_oe, 1'b0);
    rd(OFS_SLOT_ST);
    chk(v[SLOT_MAIN_EN] & v[SLOT_AUX_EN] & ~v[SLOT_REG_MODE], 1'b1);
    hi_sel <= 1'b1;
    cyc(6);
    chk(aux_hi, 1'b1);
    wr(OFS_FUNCTION, 32'h0);
    cyc(3);
    chk(aux_hi, 1'b1);
    hi_sel <= 1'b0;
    cyc(6);
    chk(aux_hi, 1'b0);
    wr(OFS_FUNCTION, 32'h1);
    cyc(3);
    chk(aux_hi, 1'b1);
    wr(OFS_FUNCTION, 32'h0);
    cyc(3);
    chk(aux_hi, 1'b0);
    foreach (cause[i]) begin
      insert <= 1'b1;
      cyc(12);
      sense <= cause[i];
      cyc(6);
      chk(flt_oe, 1'b1);
      chk(flt_d, 1'b0);
      rd(OFS_SLOT_ST);
      chk(v[SLOT_FAULT], 1'b1);
      sense <= '0;
      cyc(6);
      chk(flt_oe, 1'b1);
      insert <= 1'b0;
      cyc(12);
      chk(flt_oe, 1'b0);
    end
    insert <= 1'b1;
    cyc(12);
    sense.aux_oc <= 1'b1;
    cyc(8);
    chk(aux_out, 1'b1);
    cyc(FLT_N);
    chk(aux_out, 1'b0);
    chk(flt_oe, 1'b1);
    sense.aux_oc <= 1'b0;
    insert <= 1'b0;
    cyc(12);
    sense.slot_bled_low <= 1'b1;
    cyc(6);
    rd(OFS_SLOT_ST);
    chk(v[SLOT_PWR_OFF], 1'b1);
    sense <= '0;
    insert <= 1'b1;
    cyc(12);
    wr(OFS_CONTROL, 32'h1);
    chk(r === RESP_OKAY, 1'b1);
    insert <= 1'b0;
    cyc(12);
    chk(aux_out & ~main_out, 1'b1);
    rd(OFS_SLOT_ST);
    chk(v[SLOT_REG_MODE], 1'b1);
    wr(OFS_CONTROL, 32'h3);
    cyc(4);
    chk(main_out, 1'b1);
    sense.main12_uv <= 1'b1;
    cyc(6);
    chk(flt_oe, 1'b0);
    rd(OFS_SLOT_ST);
    chk(v[SLOT_FAULT] === 1'b0 && v[SLOT_12V_F] === 1'b1, 1'b1);
    rd(OFS_COMMON);
    chk(v[3:0] === 4'ha, 1'b1);
    rd(32'h0000_0010);
    chk(r === RESP_SLVERR && v === 32'h0, 1'b1);
    sense <= '0;
    reset_n <= 1'b0;
    force_n <= 1'b0;
    cyc(4);
    chk(aux_out | main_out, 1'b0);
    reset_n <= 1'b1;
    cyc(2);
    wait_init();
    cyc(6);
    chk(aux_out & main_out, 1'b1);
    rd(OFS_SLOT_ST);
    chk(v[SLOT_REG_MODE], 1'b0);
    results();
  end
endmodule // hpc_slot_ctrl_tb
